//--- design/apr_top.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`include "apr_consts.svh"

module apr_top #(
    parameter int SEC_CYCLES = `APR_CLK_HZ / 1000 * `APR_SECOND_MS,
    parameter int WIN_CYCLES = `APR_CLK_HZ / 1000 * `APR_SEVERE_WIN_MS,
    parameter int SEC_W = 24,
    parameter int WIN_W = 15,
    parameter int CRC_W = 9
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic crc_err_evt,
    input wire logic lcv_evt,
    input wire logic slip_evt,
    input wire logic fbit_err_evt,
    input wire logic payload_loopback,
    output apr_pkg::apr_octet_t tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    output logic irq_out_n
);
    import apr_pkg::*;

    apr_tx_state_t state;
    logic [7:0] report_config;
    logic manual_report_request;
    logic second_ready_flag;
    logic [1:0] oct2_ctl;
    logic [7:0] report_octet_three;
    logic [7:0] report_octet_four;
    logic [7:0] content_five;
    logic [7:0] content_six;
    logic [2:0] study_stage;
    logic [1:0] report_seq;
    logic [SEC_W-1:0] sec_cnt;
    logic [WIN_W-1:0] win_cnt;
    logic [CRC_W-1:0] crc_cnt;
    logic lcv_seen;
    logic slip_seen;
    logic fe_seen;
    logic se_seen;
    logic [2:0] tx_idx;
    apr_octet_t report_buf [0:`APR_REPORT_OCTETS-1];

    // bus decode
    wire [9:0] word_idx = paddr[11:2];
    wire aligned = (paddr[1:0] == 2'b00);
    wire hit_config = aligned && (word_idx == {2'b00, `APR_IDX_CONFIG});
    wire hit_manual = aligned && (word_idx == {2'b00, `APR_IDX_MANUAL});
    wire hit_status = aligned && (word_idx == {2'b00, `APR_IDX_STATUS});
    wire hit_oct2 = aligned && (word_idx == {2'b00, `APR_IDX_OCT2});
    wire hit_oct3 = aligned && (word_idx == {2'b00, `APR_IDX_OCT3});
    wire hit_oct4 = aligned && (word_idx == {2'b00, `APR_IDX_OCT4});
    wire hit_oct5 = aligned && (word_idx == {2'b00, `APR_IDX_OCT5});
    wire hit_oct6 = aligned && (word_idx == {2'b00, `APR_IDX_OCT6});
    wire hit_any = hit_config || hit_manual || hit_status || hit_oct2 || hit_oct3
                   || hit_oct4 || hit_oct5 || hit_oct6;
    wire setup_rd = psel && !penable && !pwrite;
    wire access = psel && penable;
    wire wr_ok = access && pwrite && hit_any;
    wire rd_status = access && !pwrite && hit_status;

    // zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !hit_any;

    // configuration fields
    wire auto_report_refresh = report_config[`APR_CFG_AUTO];
    wire report_irq_enable = report_config[`APR_CFG_IRQ_EN];
    wire force_crc_fail_report = report_config[`APR_CFG_FORCE];
    wire [7:0] report_octet_two = {`APR_SERVICE_POINT_ID_VALUE, oct2_ctl};

    // read value mux; bits above the octet read as zero
    wire [7:0] rd_octet = hit_config ? {2'b00, report_config[5:0]} :
                          hit_manual ? {7'h00, manual_report_request} :
                          hit_status ? {7'h00, second_ready_flag} :
                          hit_oct2 ? report_octet_two :
                          hit_oct3 ? report_octet_three :
                          hit_oct4 ? report_octet_four :
                          hit_oct5 ? content_five :
                          hit_oct6 ? content_six : 8'h00;

    // read data is captured in the setup cycle so it is stable in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= {24'h00_0000, rd_octet};
        end
    end

    // one-second divider
    wire sec_tick = (sec_cnt == SEC_W'(SEC_CYCLES - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt <= '0;
        end else if (sec_tick) begin
            sec_cnt <= '0;
        end else begin
            sec_cnt <= sec_cnt + SEC_W'(1);
        end
    end

    // a report is produced at a boundary only when the sender is free
    wire report_due = auto_report_refresh || manual_report_request;
    wire report_start = sec_tick && report_due && (state == APR_IDLE);
    wire tx_accept = tx_valid && tx_ready;
    wire tx_done = tx_accept && tx_last;

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            report_config <= `APR_RST_CONFIG;
            oct2_ctl <= 2'b00;
            report_octet_three <= `APR_RST_OCT3;
            report_octet_four <= `APR_RST_OCT4;
        end else if (wr_ok) begin
            if (hit_config) begin
                report_config <= {2'b00, pwdata[5:0]};
            end
            if (hit_oct2) begin
                oct2_ctl <= pwdata[1:0];
            end
            if (hit_oct3) begin
                report_octet_three <= pwdata[7:0];
            end
            if (hit_oct4) begin
                report_octet_four <= pwdata[7:0];
            end
        end
    end

    // manual request: a write of one sets it unless auto refresh is on, the end of the report clears it;
    // a set in the same cycle as the clear wins
    wire man_set = wr_ok && hit_manual && pwdata[0] && !auto_report_refresh;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            manual_report_request <= 1'b0;
        end else if (man_set) begin
            manual_report_request <= 1'b1;
        end else if (tx_done) begin
            manual_report_request <= 1'b0;
        end
    end

    // per-second flag: boundary set wins over the clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_ready_flag <= 1'b0;
        end else if (sec_tick) begin
            second_ready_flag <= 1'b1;
        end else if (rd_status) begin
            second_ready_flag <= 1'b0;
        end
    end

    // interrupt pin, active low
    assign irq_out_n = !(report_irq_enable && second_ready_flag);

    // interval counters; an event on the boundary counts in the new interval
    wire win_open = (win_cnt != '0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_cnt <= '0;
            lcv_seen <= 1'b0;
            slip_seen <= 1'b0;
            fe_seen <= 1'b0;
            se_seen <= 1'b0;
        end else if (sec_tick) begin
            crc_cnt <= crc_err_evt ? CRC_W'(1) : '0;
            lcv_seen <= lcv_evt;
            slip_seen <= slip_evt;
            fe_seen <= fbit_err_evt;
            se_seen <= fbit_err_evt && win_open;
        end else begin
            if (crc_err_evt && (crc_cnt != '1)) begin
                crc_cnt <= crc_cnt + CRC_W'(1);
            end
            lcv_seen <= lcv_seen || lcv_evt;
            slip_seen <= slip_seen || slip_evt;
            fe_seen <= fe_seen || fbit_err_evt;
            se_seen <= se_seen || (fbit_err_evt && win_open);
        end
    end

    // severe framing window restarts on each framing bit error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt <= '0;
        end else if (fbit_err_evt) begin
            win_cnt <= WIN_W'(WIN_CYCLES - 1);
        end else if (win_open) begin
            win_cnt <= win_cnt - WIN_W'(1);
        end
    end

    // crc grades
    logic [5:0] crc_grade_bits;
    apr_grade #(
        .CW(CRC_W)
    ) u_grade (
        .crc_count(crc_cnt),
        .force_fail(force_crc_fail_report),
        .grade(crc_grade_bits)
    );

    // framing flags; forcing overrides the measured ones
    wire severe_framing_flag = force_crc_fail_report || se_seen;
    wire framing_bit_error_flag = !force_crc_fail_report && fe_seen && !se_seen;
    wire top_crc_grade_bit = crc_grade_bits[5];
    wire sync_study_bit_a = study_stage[1];
    wire sync_study_bit_b = study_stage[0];
    wire [1:0] next_seq = report_seq - 2'b01; // modulo-4 count runs 00, 11, 10, 01

    // report content octets
    wire [7:0] next_five = {crc_grade_bits[2], lcv_seen, crc_grade_bits[3], sync_study_bit_a,
                            sync_study_bit_b, crc_grade_bits[4], slip_seen, top_crc_grade_bit};
    wire [7:0] next_six = {framing_bit_error_flag, severe_framing_flag, payload_loopback,
                           crc_grade_bits[0], study_stage[2], crc_grade_bits[1], report_seq};

    // holding registers and study staging; the staged copy is one update
    // behind, so a new study or reserved value needs two updates to show
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            content_five <= 8'h00;
            content_six <= 8'h00;
            study_stage <= 3'b000;
            report_seq <= 2'b00;
        end else if (report_start) begin
            content_five <= next_five;
            content_six <= next_six;
            study_stage <= {report_config[`APR_CFG_RSV], report_config[`APR_CFG_STUDY_A],
                            report_config[`APR_CFG_STUDY_B]};
            report_seq <= next_seq;
        end
    end

    // snapshot of the report so software writes cannot tear a frame
    always_ff @(posedge pclk) begin
        if (report_start) begin
            report_buf[0] <= report_octet_two;
            report_buf[1] <= report_octet_three;
            report_buf[2] <= report_octet_four;
            report_buf[3] <= next_five;
            report_buf[4] <= next_six;
        end
    end

    // transmit sequencer
    assign tx_valid = (state == APR_SEND);
    assign tx_last = tx_valid && (tx_idx == 3'(`APR_REPORT_OCTETS - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= APR_IDLE;
            tx_idx <= 3'b000;
            tx_data <= 8'h00;
        end else begin
            case (state)
                APR_IDLE: begin
                    if (report_start) begin
                        state <= APR_SEND;
                        tx_idx <= 3'b000;
                        tx_data <= report_octet_two;
                    end
                end
                APR_SEND: begin
                    if (tx_done) begin
                        state <= APR_IDLE;
                    end else if (tx_accept) begin
                        tx_idx <= tx_idx + 3'b001;
                        tx_data <= report_buf[tx_idx + 3'b001];
                    end
                end
                default: begin
                    state <= APR_IDLE;
                end
            endcase
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_flag_boundary: assert property (sec_tick |=> second_ready_flag)
        else $error("ready flag not set at second boundary");
    chk_flag_read: assert property (rd_status && !sec_tick |=> !second_ready_flag)
        else $error("status read did not clear ready flag");
    chk_irq_enabled: assert property (second_ready_flag && report_irq_enable |-> !irq_out_n)
        else $error("interrupt not asserted");
    chk_irq_masked: assert property (!report_irq_enable |-> irq_out_n)
        else $error("interrupt asserted while disabled");
    chk_auto_start: assert property (sec_tick && auto_report_refresh && !tx_valid
                                     |=> tx_valid && tx_data == $past(report_octet_two))
        else $error("auto report did not start with octet two");
    chk_manual_idle: assert property (sec_tick && !report_due && !tx_valid |=> !tx_valid)
        else $error("report sent without request");
    chk_man_set: assert property (man_set |=> manual_report_request)
        else $error("manual request not set");
    chk_man_clear: assert property (tx_done && !man_set |=> !manual_report_request)
        else $error("manual request not cleared after last octet");
    chk_force_bits: assert property (report_start && force_crc_fail_report
                                     |=> content_five[0] && content_six[6] && !content_six[7]
                                     && content_six[4] == 1'b0 && content_five[7] == 1'b0)
        else $error("forced fail report bits wrong");
    chk_service_point_id_const: assert property (report_octet_two[7:2] == `APR_SERVICE_POINT_ID_VALUE)
        else $error("service point id not fourteen");
    chk_content_flag: assert property (report_start |=> second_ready_flag
                                       && content_six == $past(next_six))
        else $error("content not updated with flag");
    chk_frame_len: assert property (tx_accept && !tx_last |=> tx_valid)
        else $error("report frame cut short");

    cov_auto_report: cover property (report_start && auto_report_refresh);
    cov_manual_report: cover property (tx_done && manual_report_request);
    cov_stall: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
    cov_flag_race: cover property (sec_tick && rd_status);

endmodule : apr_top

//--- design/apr_consts.svh
`ifndef APR_CONSTS_SVH
`define APR_CONSTS_SVH

// register indices; byte address is four times the index
`define APR_IDX_CONFIG 8'h78
`define APR_IDX_MANUAL 8'h79
`define APR_IDX_STATUS 8'h7A
`define APR_IDX_OCT2 8'h7B
`define APR_IDX_OCT3 8'h7C
`define APR_IDX_OCT4 8'h7D
`define APR_IDX_OCT5 8'h7E
`define APR_IDX_OCT6 8'h7F

// configuration field positions
`define APR_CFG_AUTO 0
`define APR_CFG_IRQ_EN 1
`define APR_CFG_FORCE 2
`define APR_CFG_STUDY_B 3
`define APR_CFG_STUDY_A 4
`define APR_CFG_RSV 5

// reset values
`define APR_RST_CONFIG 8'h00
`define APR_RST_OCT2 8'h38
`define APR_RST_OCT3 8'h01
`define APR_RST_OCT4 8'h03
`define APR_SERVICE_POINT_ID_VALUE 6'h0E

// timing
`define APR_CLK_HZ 10000000
`define APR_SECOND_MS 1000
`define APR_SEVERE_WIN_MS 3

// crc grade thresholds
`define APR_CRC_G2_MAX 5
`define APR_CRC_G3_MAX 10
`define APR_CRC_G4_MAX 100
`define APR_CRC_G6_MIN 320

// report framing
`define APR_REPORT_OCTETS 5

`endif

//--- design/apr_pkg.sv
package apr_pkg;

    // transmit sequencer states
    typedef enum logic [1:0] {
        APR_IDLE = 2'b00,
        APR_SEND = 2'b01
    } apr_tx_state_t;

    typedef logic [7:0] apr_octet_t;

endpackage : apr_pkg

//--- design/apr_grade.sv
`timescale 1ns/1ns
`include "apr_consts.svh"

module apr_grade #(
    parameter int CW = 9
) (
    input wire logic [CW-1:0] crc_count,
    input wire logic force_fail,
    output logic [5:0] grade
);

    logic [CW-1:0] lim_g2;
    logic [CW-1:0] lim_g3;
    logic [CW-1:0] lim_g4;
    logic [CW-1:0] lim_g6;
    logic [CW-1:0] one;

    // thresholds at the counter width
    assign lim_g2 = CW'(`APR_CRC_G2_MAX);
    assign lim_g3 = CW'(`APR_CRC_G3_MAX);
    assign lim_g4 = CW'(`APR_CRC_G4_MAX);
    assign lim_g6 = CW'(`APR_CRC_G6_MIN);
    assign one = CW'(1);

    // grade bits; forcing a failed report keeps only the top grade
    assign grade[0] = !force_fail && (crc_count == one);
    assign grade[1] = !force_fail && (crc_count > one) && (crc_count <= lim_g2);
    assign grade[2] = !force_fail && (crc_count > lim_g2) && (crc_count <= lim_g3);
    assign grade[3] = !force_fail && (crc_count > lim_g3) && (crc_count <= lim_g4);
    assign grade[4] = !force_fail && (crc_count > lim_g4) && (crc_count < lim_g6);
    assign grade[5] = force_fail || (crc_count >= lim_g6);

endmodule : apr_grade

//--- tb/apr_link_model.sv
`timescale 1ns/1ns
// behavioural data-link transmitter: takes report octets, may stall
module apr_link_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire apr_pkg::apr_octet_t tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic acc,
    output apr_pkg::apr_octet_t acc_data,
    output logic acc_last
);
    import apr_pkg::*;
    // a slow link toggles ready, so the sender must hold each octet across stalls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
            acc <= 1'b0;
            acc_data <= 8'h00;
            acc_last <= 1'b0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            acc <= tx_valid && tx_ready;
            acc_data <= tx_data;
            acc_last <= tx_last;
        end
    end
endmodule : apr_link_model

//--- tb/t1_auto_perf_report_control_test.sv
`timescale 1ns/1ns
`include "apr_consts.svh"
module t1_auto_perf_report_control_test;
    import apr_pkg::*;
    localparam logic [11:0] A_CFG = {2'b00, `APR_IDX_CONFIG, 2'b00};
    localparam logic [11:0] A_MAN = {2'b00, `APR_IDX_MANUAL, 2'b00};
    localparam logic [11:0] A_STS = {2'b00, `APR_IDX_STATUS, 2'b00};
    localparam logic [11:0] A_O2 = {2'b00, `APR_IDX_OCT2, 2'b00};
    localparam logic [11:0] A_O3 = {2'b00, `APR_IDX_OCT3, 2'b00};
    localparam logic [11:0] A_O4 = {2'b00, `APR_IDX_OCT4, 2'b00};
    localparam logic [11:0] A_C5 = {2'b00, `APR_IDX_OCT5, 2'b00};
    localparam logic [11:0] A_C6 = {2'b00, `APR_IDX_OCT6, 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, tx_valid, tx_last, tx_ready, irq_out_n, acc, acc_last;
    logic crc_err_evt = 1'b0;
    logic lcv_evt = 1'b0;
    logic slip_evt = 1'b0;
    logic fbit_err_evt = 1'b0;
    logic payload_loopback = 1'b0;
    logic slow = 1'b0;
    apr_octet_t tx_data, acc_data, o3, o4;
    logic [15:0] lfsr = 16'hE703;
    logic [8:0] exp_e;
    logic [8:0] expq[$];
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int num_checks = 0;
    int frames = 0;

    always #50 pclk = ~pclk;

    apr_top #(.SEC_CYCLES(50), .WIN_CYCLES(5)) u_apr_top (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .crc_err_evt(crc_err_evt),
        .lcv_evt(lcv_evt), .slip_evt(slip_evt), .fbit_err_evt(fbit_err_evt),
        .payload_loopback(payload_loopback), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready), .irq_out_n(irq_out_n));

    apr_link_model u_apr_link_model (.pclk(pclk), .presetn(presetn), .slow(slow),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .acc(acc), .acc_data(acc_data), .acc_last(acc_last));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // one APB transfer, held until pready is sampled high, then one idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string what);
        apb(1'b0, a, 8'h00);
        check(rd, {24'h000000, exp}, what);
    endtask : rd_chk

    // octet six carries a rolling sequence count in bits 1:0, masked by the monitor
    task automatic push_frame(input logic [7:0] v5, input logic [7:0] v6);
        expq.push_back({1'b0, 8'h3B});
        expq.push_back({1'b0, o3});
        expq.push_back({1'b0, o4});
        expq.push_back({1'b0, v5});
        expq.push_back({1'b1, v6});
    endtask : push_frame

    task automatic wait_frames(input int n);
        for (int i = 0; i < 400 && frames < n; i++) @(posedge pclk);
        check(frames, n, "frame count");
    endtask : wait_frames

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize

    // monitor: each accepted octet is matched against the oldest note
    always @(posedge pclk) begin
        if (acc === 1'b1) begin
            if (expq.size() == 0) begin
                num_errors++;
                $display("[ERR] %0t unexpected report octet %h", $time, acc_data);
            end else begin
                exp_e = expq.pop_front();
                check({acc_last, acc_data & (acc_last ? 8'hFC : 8'hFF)}, exp_e, "octet");
                if (acc_last === 1'b1) frames++;
            end
        end
    end

    initial begin
        #(100 * 4000);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(irq_out_n, 1'b1, "irq idle");
        rd_chk(A_CFG, 8'h00, "config reset");
        rd_chk(A_MAN, 8'h00, "manual reset");
        rd_chk(A_O2, 8'h38, "octet two reset");
        rd_chk(A_O3, 8'h01, "octet three reset");
        rd_chk(A_O4, 8'h03, "octet four reset");
        apb(1'b0, 12'h200, 8'h00);
        check(er, 1'b1, "unmapped refused");
        $display("test reset values done");
        // manual forced-fail report through a stalling link
        wr_oct();
        rd_chk(A_O2, 8'h3B, "octet two fixed id");
        apb(1'b1, A_CFG, 8'h04);
        push_frame(8'h01, 8'h40);
        slow <= 1'b1;
        apb(1'b1, A_MAN, 8'h01);
        rd_chk(A_MAN, 8'h01, "manual pending");
        for (int i = 0; i < 100 && rd[0] !== 1'b0; i++) apb(1'b0, A_MAN, 8'h00);
        check(rd, 32'h00000000, "manual cleared");
        wait_frames(1);
        check(irq_out_n, 1'b1, "irq disabled");
        slow <= 1'b0;
        repeat (60) @(posedge pclk);
        check(frames, 1, "no report unrequested");
        $display("test manual report done");
        // automatic reports with interrupt and delayed study bits
        apb(1'b0, A_STS, 8'h00);
        apb(1'b1, A_CFG, 8'h37);
        push_frame(8'h01, 8'h40);
        push_frame(8'h11, 8'h48);
        for (int i = 0; i < 80 && irq_out_n !== 1'b0; i++) @(posedge pclk);
        check(irq_out_n, 1'b0, "irq asserted");
        rd_chk(A_STS, 8'h01, "ready flag");
        check(irq_out_n, 1'b1, "irq cleared by read");
        rd_chk(A_C5, 8'h01, "content octet five");
        wait_frames(3);
        apb(1'b1, A_CFG, 8'h00);
        $display("test auto report done");
        // graded report from real error events
        apb(1'b0, A_STS, 8'h00);
        for (int i = 0; i < 40 && rd[0] !== 1'b1; i++) apb(1'b0, A_STS, 8'h00);
        check(rd[0], 1'b1, "boundary seen");
        payload_loopback <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            crc_err_evt <= 1'b1;
            lcv_evt <= (i == 0);
            slip_evt <= (i == 0);
            fbit_err_evt <= (i == 0);
            @(posedge pclk);
            crc_err_evt <= 1'b0;
            lcv_evt <= 1'b0;
            slip_evt <= 1'b0;
            fbit_err_evt <= 1'b0;
            @(posedge pclk);
        end
        push_frame(8'h52, 8'hAC);
        apb(1'b1, A_MAN, 8'h01);
        wait_frames(4);
        // fourth report carries sequence count 01 in bits 1:0
        rd_chk(A_C6, 8'hAD, "content octet six");
        $display("test graded report done");
        summarize();
    end

    // octet registers: id bits ignore writes, octet two control bits take ones, octets three and four take random values
    task automatic wr_oct;
        apb(1'b1, A_O2, 8'hFF);
        lfsr = lfsr_next(lfsr);
        o3 = lfsr[7:0];
        apb(1'b1, A_O3, o3);
        lfsr = lfsr_next(lfsr);
        o4 = lfsr[7:0];
        apb(1'b1, A_O4, o4);
        rd_chk(A_O3, o3, "octet three");
        rd_chk(A_O4, o4, "octet four");
    endtask : wr_oct
endmodule : t1_auto_perf_report_control_test
